/* hw/homing_map.vh */
// constants of the homing sequencer: register offsets, status bits,
// method codes, reset values and timing figures.
// assumes inclusion by bare name from the hw/ design files that use it; the edge synchroniser does not.
`ifndef HOMING_MAP_VH
`define HOMING_MAP_VH

////////////////////////////////////////////////////////////////////////
// register byte offsets on the plain register port
`define OFS_CONTROL_WORD   8'h00
`define OFS_HOMING_METHOD  8'h04
`define OFS_HIGH_VELOCITY  8'h08
`define OFS_LOW_VELOCITY   8'h0C
`define OFS_HOMING_ACCEL   8'h10
`define OFS_TORQUE_STOP    8'h14
`define OFS_DONE_DELAY     8'h18
`define OFS_STATUS_WORD    8'h1C

////////////////////////////////////////////////////////////////////////
// control and status word bit positions
`define CW_HOMING_START    4
`define SW_ABNORMAL_STOP   8
`define SW_POS_REACHED     10
`define SW_HOMING_DONE     12
`define SW_HOMING_ERROR    13
`define SW_PARAM_ZERO      14
`define SW_HOMING_ACTIVE   15

////////////////////////////////////////////////////////////////////////
// reset values
`define RST_CONTROL_WORD   16'h0000
`define RST_HOMING_METHOD  8'h00
`define RST_VELOCITY       32'h00000000
`define RST_ACCEL          32'h00000000
`define RST_TORQUE_STOP    16'h0000
`define RST_DONE_DELAY     16'h0000

////////////////////////////////////////////////////////////////////////
// homing method codes, two's complement in eight bits
`define METH_TQ_NEG_LOW    8'hFA
`define METH_TQ_POS_LOW    8'hFB
`define METH_TQ_NEG_REV    8'hFC
`define METH_TQ_POS_REV    8'hFD
`define METH_TQ_NEG_IDX    8'hFE
`define METH_TQ_POS_IDX    8'hFF
`define METH_NEG_LIMIT     8'h01
`define METH_POS_LIMIT     8'h02
`define METH_HOME_POS_A    8'h03
`define METH_HOME_POS_B    8'h04
`define METH_HOME_NEG_A    8'h05
`define METH_HOME_NEG_B    8'h06
`define METH_INDEX_NEG     8'h21
`define METH_INDEX_POS     8'h22

////////////////////////////////////////////////////////////////////////
// timing: done delay counts in units of one millisecond
`define CLK_PERIOD_NS      100
`define DELAY_UNIT_NS      1000000

`endif

/* hw/edge_sync.v */
// two-flop synchroniser with edge detection for one pin input.
// assumes the pin is asynchronous to i_ref_clk; state frozen while i_ce low.
module edge_sync (
    input  wire i_ref_clk,
    input  wire i_resetn,
    input  wire i_ce,
    input  wire i_pin,
    output wire o_level,
    output wire o_rise,
    output wire o_fall
);

    reg meta_r;
    reg level_r;
    reg prev_r;

    ////////////////////////////////////////////////////////////////////
    // meta_r feeds only level_r; edges come from the settled stages
    always @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_r  <= 1'b0;
            level_r <= 1'b0;
            prev_r  <= 1'b0;
        end else if (i_ce) begin
            meta_r  <= i_pin;
            level_r <= meta_r;
            prev_r  <= level_r;
        end
    end

    assign o_level = level_r;
    assign o_rise  = level_r & ~prev_r;
    assign o_fall  = ~level_r & prev_r;

endmodule // edge_sync

/* hw/done_delay_timer.v */
// millisecond delay timer for the homing done signal.
// assumes a one-cycle start pulse; expiry is a one-cycle pulse.
`include "homing_map.vh"

module done_delay_timer #(
    parameter [15:0] TICK_CYCLES = 16'd10000
) (
    input  wire        i_ref_clk,
    input  wire        i_resetn,
    input  wire        i_ce,
    input  wire        i_start,
    input  wire        i_abort,
    input  wire [15:0] i_delay_ms,
    output wire        o_expired
);

    reg        busy_r;
    reg [15:0] tick_r;
    reg [15:0] ms_r;
    reg        exp_r;

    ////////////////////////////////////////////////////////////////////
    // prescaler to whole milliseconds, then count down the delay
    always @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            busy_r <= 1'b0;
            tick_r <= 16'h0000;
            ms_r   <= 16'h0000;
            exp_r  <= 1'b0;
        end else if (i_ce) begin
            exp_r <= 1'b0;
            if (i_abort) begin
                busy_r <= 1'b0;
            end else if (i_start) begin
                busy_r <= 1'b1;
                tick_r <= 16'h0000;
                ms_r   <= i_delay_ms;
            end else if (busy_r) begin
                if (ms_r == 16'h0000) begin
                    busy_r <= 1'b0; // zero delay expires at once
                    exp_r  <= 1'b1;
                end else if (tick_r == TICK_CYCLES - 16'd1) begin
                    tick_r <= 16'h0000;
                    ms_r   <= ms_r - 16'd1;
                end else begin
                    tick_r <= tick_r + 16'd1;
                end
            end
        end
    end

    assign o_expired = exp_r;

endmodule // done_delay_timer

/* hw/servo_homing_sequencer.v */
// homing sequencer: runs the selected homing method, drives motion
// requests and reports homing progress in the status word.
// assumes a motion loop downstream follows o_run/o_dir_pos/o_velocity,
// and that i_torque is produced on i_ref_clk by that loop.
//
// Function
// [R1] homing start with absolute encoder is error
// [R2] both limits seen during homing is error
// [R3] negative limit errors in positive-limit methods
// [R4] positive limit errors in negative-limit methods
// [R5] any limit errors in methods 3,4,19,20
// [R6] limit or home errors in index-only methods
// [R7] error sets status bit 13, stops motor
// [R8] -6/-5 slow search, torque stop, delayed done
// [R9] -4/-3 fast, reverse on torque, delayed done
// [R10] -2/-1 fast, reverse, stop on index
// [R11] method 1 from clear negative limit
// [R12] method 1 starting on negative limit
// [R13] method 2 from clear positive limit
// [R14] method 2 starting on positive limit
// [R15] method 3 home switch, negative index search
// [R16] method 4 home switch, positive index search
// [R17] method 5 home switch, positive index search
// [R18] method 6 home switch, negative index search
// [R19] master judges completion from bits 10/12
// [R20] bit 4 rise starts, fall stops homing
// [R21] done bit 12 only with bit 10
// [R22] status bit 14 flags zero parameters
// [R23] pins synchronised, searches end on edges
`include "homing_map.vh"

module servo_homing_sequencer #(
    parameter [15:0] TICK_CYCLES = 16'd10000 // cycles per delay millisecond
) (
    input  wire        i_ref_clk,
    input  wire        i_resetn,
    input  wire        i_ce,
    input  wire [7:0]  i_addr,
    input  wire [31:0] i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [31:0] o_rdata,
    input  wire        i_pos_limit,
    input  wire        i_neg_limit,
    input  wire        i_home_switch,
    input  wire        i_index_pulse,
    input  wire        i_abs_encoder,
    input  wire [15:0] i_torque,
    output reg         o_run,
    output reg         o_dir_pos,
    output reg  [31:0] o_velocity,
    output reg  [31:0] o_accel,
    output reg  [15:0] o_status_word
);

    localparam [2:0] S_IDLE  = 3'd0;
    localparam [2:0] S_MOVE  = 3'd1;
    localparam [2:0] S_DELAY = 3'd2;
    localparam [2:0] S_DONE  = 3'd3;
    localparam [2:0] S_STOP  = 3'd4;
    localparam [2:0] S_ERROR = 3'd5;

    ////////////////////////////////////////////////////////////////////
    // software registers
    reg [15:0] control_r;
    reg [7:0]  method_r;
    reg [31:0] high_vel_r;
    reg [31:0] low_vel_r;
    reg [31:0] accel_r;
    reg [15:0] torque_stop_threshold_r;
    reg [15:0] done_signal_delay_r;

    reg [2:0]  state_r;
    reg [1:0]  phase_r;
    reg        error_r;
    reg        start_prev_r;

    wire pos_lvl;
    wire neg_lvl;
    wire home_lvl;
    wire idx_rise;
    wire abs_lvl;
    wire delay_done;

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    edge_sync u_pos_sync (.i_ref_clk (i_ref_clk), .i_resetn (i_resetn), .i_ce (i_ce),
        .i_pin (i_pos_limit), .o_level (pos_lvl), .o_rise (), .o_fall ()); // R23
    edge_sync u_neg_sync (.i_ref_clk (i_ref_clk), .i_resetn (i_resetn), .i_ce (i_ce),
        .i_pin (i_neg_limit), .o_level (neg_lvl), .o_rise (), .o_fall ()); // R23
    edge_sync u_home_sync (.i_ref_clk (i_ref_clk), .i_resetn (i_resetn), .i_ce (i_ce),
        .i_pin (i_home_switch), .o_level (home_lvl), .o_rise (), .o_fall ()); // R23
    edge_sync u_index_sync (.i_ref_clk (i_ref_clk), .i_resetn (i_resetn), .i_ce (i_ce),
        .i_pin (i_index_pulse), .o_level (), .o_rise (idx_rise), .o_fall ()); // R23
    edge_sync u_abs_sync (.i_ref_clk (i_ref_clk), .i_resetn (i_resetn), .i_ce (i_ce),
        .i_pin (i_abs_encoder), .o_level (abs_lvl), .o_rise (), .o_fall ());

    ////////////////////////////////////////////////////////////////////
    // start/stop edges of control bit 4 and parameter check
    wire start_bit   = control_r[`CW_HOMING_START];
    wire start_req   = start_bit & ~start_prev_r; // R20
    wire stop_req    = ~start_bit & start_prev_r; // R20
    wire param_zero  = (method_r == 8'h00) | (high_vel_r == 32'h00000000) |
                       (low_vel_r == 32'h00000000) |
                       (accel_r == 32'h00000000); // R22
    wire [15:0] tq_abs = i_torque[15] ? (16'h0000 - i_torque) : i_torque;
    wire tq_hit      = (tq_abs >= torque_stop_threshold_r);

    ////////////////////////////////////////////////////////////////////
    // method families for the limit checks
    reg uses_pos_lim;
    reg uses_neg_lim;
    reg no_lim;
    reg index_only;

    always @* begin
        uses_pos_lim = 1'b0;
        uses_neg_lim = 1'b0;
        no_lim       = 1'b0;
        index_only   = 1'b0;
        case (method_r)
            8'h02, 8'h07, 8'h08, 8'h09, 8'h0A,
            8'h17, 8'h18, 8'h19, 8'h1A: uses_pos_lim = 1'b1; // R3
            8'h01, 8'h0B, 8'h0C, 8'h0D, 8'h0E,
            8'h1B, 8'h1C, 8'h1D, 8'h1E: uses_neg_lim = 1'b1; // R4
            8'h03, 8'h04, 8'h13, 8'h14: no_lim = 1'b1;       // R5
            8'h21, 8'h22:               index_only = 1'b1;   // R6
            default: ;
        endcase
    end

    // methods outside this set fail at start rather than run blind
    wire supported = (method_r >= `METH_TQ_NEG_LOW) ||
                     (method_r >= `METH_NEG_LIMIT && method_r <= `METH_HOME_NEG_B) ||
                     (method_r == `METH_INDEX_NEG) || (method_r == `METH_INDEX_POS);

    // forbidden pin conditions while a run is in motion
    wire run_fault = (pos_lvl & neg_lvl) |                 // R2
                     (uses_pos_lim & neg_lvl) |            // R3
                     (uses_neg_lim & pos_lvl) |            // R4
                     (no_lim & (pos_lvl | neg_lvl)) |      // R5
                     (index_only & (pos_lvl | neg_lvl | home_lvl)); // R6

    ////////////////////////////////////////////////////////////////////
    // per-phase motion: direction, speed, end condition, last step
    reg       step_dir;
    reg       step_fast;
    reg       step_end;
    reg       step_last;
    reg       step_delay;
    reg [1:0] first_phase;

    always @* begin
        step_dir    = 1'b0;
        step_fast   = 1'b0;
        step_end    = 1'b0;
        step_last   = 1'b0;
        step_delay  = 1'b0;
        first_phase = 2'd0;
        case (method_r)
            `METH_TQ_NEG_LOW, `METH_TQ_POS_LOW: begin
                step_dir   = (method_r == `METH_TQ_POS_LOW); // R8
                step_end   = tq_hit;                         // R8
                step_last  = 1'b1;
                step_delay = 1'b1;
            end
            `METH_TQ_NEG_REV, `METH_TQ_POS_REV,
            `METH_TQ_NEG_IDX, `METH_TQ_POS_IDX: begin
                // reverse leg runs slow so the stop point repeats well
                step_dir  = method_r[0] ^ phase_r[0];
                step_fast = (phase_r == 2'd0);
                if (phase_r == 2'd0) begin
                    step_end = tq_hit; // R9 R10
                end else if (method_r[1]) begin
                    step_end  = ~tq_hit & idx_rise; // R10 R23
                    step_last = 1'b1;
                end else begin
                    step_end   = ~tq_hit; // R9
                    step_last  = 1'b1;
                    step_delay = 1'b1;    // R9
                end
            end
            `METH_NEG_LIMIT, `METH_POS_LIMIT: begin
                // method 1 uses the negative limit, method 2 the positive
                first_phase = (method_r[1] ? pos_lvl : neg_lvl) ? 2'd0 : 2'd1;
                case (phase_r)
                    2'd0: begin
                        step_dir  = ~method_r[1];
                        step_fast = 1'b1;
                        step_end  = method_r[1] ? ~pos_lvl : ~neg_lvl; // R12 R14
                    end
                    2'd1: begin
                        step_dir  = method_r[1];
                        step_fast = 1'b1;
                        step_end  = method_r[1] ? pos_lvl : neg_lvl; // R11 R13
                    end
                    default: begin
                        step_dir  = ~method_r[1];
                        step_end  = idx_rise &
                                    (method_r[1] ? ~pos_lvl : ~neg_lvl); // R11 R13
                        step_last = 1'b1;
                    end
                endcase
            end
            `METH_HOME_POS_A, `METH_HOME_NEG_A: begin
                // method 3 seeks positive, method 5 the mirror image
                first_phase = home_lvl ? 2'd0 : 2'd1;
                step_dir    = method_r[2] ^ (phase_r == 2'd1);
                step_fast   = (phase_r != 2'd2);
                case (phase_r)
                    2'd0:    step_end = ~home_lvl;          // R15 R17
                    2'd1:    step_end = home_lvl;           // R15 R17
                    default: begin
                        step_end  = idx_rise & ~home_lvl;   // R15 R17
                        step_last = 1'b1;
                    end
                endcase
            end
            `METH_HOME_POS_B, `METH_HOME_NEG_B: begin
                // method 4 finishes positive, method 6 negative
                first_phase = home_lvl ? 2'd1 : 2'd0;
                step_dir    = method_r[1] ^ (phase_r != 2'd1);
                step_fast   = (phase_r != 2'd2);
                case (phase_r)
                    2'd0:    step_end = home_lvl;           // R16 R18
                    2'd1:    step_end = ~home_lvl;          // R16 R18
                    default: begin
                        step_end  = idx_rise & home_lvl;    // R16 R18
                        step_last = 1'b1;
                    end
                endcase
            end
            `METH_INDEX_NEG, `METH_INDEX_POS: begin
                first_phase = 2'd2;
                step_dir    = (method_r == `METH_INDEX_POS);
                step_end    = idx_rise; // R23
                step_last   = 1'b1;
            end
            default: ;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // delay before done on torque methods -6 to -3
    done_delay_timer #(.TICK_CYCLES (TICK_CYCLES)) u_done_delay (
        .i_ref_clk (i_ref_clk), .i_resetn (i_resetn), .i_ce (i_ce),
        .i_start (state_r == S_MOVE && step_end && step_last && step_delay),
        .i_abort (state_r != S_DELAY && state_r != S_MOVE),
        .i_delay_ms (done_signal_delay_r), .o_expired (delay_done));

    ////////////////////////////////////////////////////////////////////
    // sequencer; stop and error take priority over phase progress
    always @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_r      <= S_IDLE;
            phase_r      <= 2'd0;
            error_r      <= 1'b0;
            start_prev_r <= 1'b0;
        end else if (i_ce) begin
            start_prev_r <= start_bit;
            if (start_req) begin
                if (abs_lvl || !supported) begin
                    state_r <= S_ERROR; // R1
                    error_r <= 1'b1;    // R1 R7
                end else if (!param_zero) begin
                    state_r <= S_MOVE;
                    phase_r <= first_phase;
                    error_r <= 1'b0;
                end
            end else if (stop_req &&
                         (state_r == S_MOVE || state_r == S_DELAY)) begin
                state_r <= S_STOP; // R20
            end else if (state_r == S_MOVE) begin
                if (run_fault) begin
                    state_r <= S_ERROR; // R7
                    error_r <= 1'b1;    // R7
                end else if (step_end) begin
                    if (!step_last) begin
                        phase_r <= phase_r + 2'd1;
                    end else if (step_delay) begin
                        state_r <= S_DELAY; // R8 R9
                    end else begin
                        state_r <= S_DONE;
                    end
                end
            end else if (state_r == S_DELAY && delay_done) begin
                state_r <= S_DONE; // R8 R9
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // motion request and status outputs, all registered
    always @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_run         <= 1'b0;
            o_dir_pos     <= 1'b0;
            o_velocity    <= 32'h00000000;
            o_accel       <= 32'h00000000;
            o_status_word <= 16'h0000;
        end else if (i_ce) begin
            // run drops on the same edge as an error or stop decision
            o_run      <= (state_r == S_MOVE) && !run_fault && !stop_req &&
                          !(step_end && step_last) && !start_req; // R7
            o_dir_pos  <= step_dir;
            o_velocity <= step_fast ? high_vel_r : low_vel_r;
            o_accel    <= accel_r;
            o_status_word <= 16'h0000;
            o_status_word[`SW_POS_REACHED]   <= (state_r == S_DONE) ||
                                                (state_r == S_STOP) ||
                                                (state_r == S_ERROR); // R21
            o_status_word[`SW_HOMING_DONE]   <= (state_r == S_DONE); // R21 R19
            o_status_word[`SW_HOMING_ERROR]  <= error_r;            // R7
            o_status_word[`SW_ABNORMAL_STOP] <= (state_r == S_ERROR);
            o_status_word[`SW_PARAM_ZERO]    <= param_zero;         // R22
            o_status_word[`SW_HOMING_ACTIVE] <= (state_r == S_MOVE) ||
                                                (state_r == S_DELAY);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register writes
    always @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            control_r               <= `RST_CONTROL_WORD;
            method_r                <= `RST_HOMING_METHOD;
            high_vel_r              <= `RST_VELOCITY;
            low_vel_r               <= `RST_VELOCITY;
            accel_r                 <= `RST_ACCEL;
            torque_stop_threshold_r <= `RST_TORQUE_STOP;
            done_signal_delay_r     <= `RST_DONE_DELAY;
        end else if (i_ce && i_wr) begin
            case (i_addr)
                `OFS_CONTROL_WORD:  control_r  <= i_wdata[15:0];
                `OFS_HOMING_METHOD: method_r   <= i_wdata[7:0];
                `OFS_HIGH_VELOCITY: high_vel_r <= i_wdata;
                `OFS_LOW_VELOCITY:  low_vel_r  <= i_wdata;
                `OFS_HOMING_ACCEL:  accel_r    <= i_wdata;
                `OFS_TORQUE_STOP:   torque_stop_threshold_r <= i_wdata[15:0];
                `OFS_DONE_DELAY:    done_signal_delay_r     <= i_wdata[15:0];
                default: ; // status word is read only
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data stands only in the cycle after the read strobe
    always @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= 32'h00000000;
        end else if (i_ce) begin
            o_rdata <= 32'h00000000;
            if (i_rd) begin
                case (i_addr)
                    `OFS_CONTROL_WORD:  o_rdata <= {16'h0000, control_r};
                    `OFS_HOMING_METHOD: o_rdata <= {24'h000000, method_r};
                    `OFS_HIGH_VELOCITY: o_rdata <= high_vel_r;
                    `OFS_LOW_VELOCITY:  o_rdata <= low_vel_r;
                    `OFS_HOMING_ACCEL:  o_rdata <= accel_r;
                    `OFS_TORQUE_STOP:   o_rdata <= {16'h0000, torque_stop_threshold_r};
                    `OFS_DONE_DELAY:    o_rdata <= {16'h0000, done_signal_delay_r};
                    `OFS_STATUS_WORD:   o_rdata <= {16'h0000, o_status_word};
                    default:            o_rdata <= 32'h00000000;
                endcase
            end
        end
    end

endmodule // servo_homing_sequencer

/* dv/servo_homing_chk.sv */
// port checker of the homing sequencer.
// assumes i_ce is held high by the bench.
module servo_homing_chk (
    input wire        i_ref_clk,
    input wire        i_resetn,
    input wire        i_rd,
    input wire        i_pos_limit,
    input wire        i_neg_limit,
    input wire        i_abs_encoder,
    input wire [31:0] o_rdata,
    input wire        o_run,
    input wire [15:0] o_status_word
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    // read data must not linger, or a poll could see stale status
    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data not idle");
    done_reach_a: assert property (o_status_word[12] |-> o_status_word[10])
        else $error("done without position reached");
    run_done_a: assert property (o_run |-> !o_status_word[12])
        else $error("done while moving");
    error_stop_a: assert property (o_status_word[13] |-> !o_run)
        else $error("moving with homing error");
    error_flag_a: assert property ($rose(o_status_word[13]) |-> o_status_word[8])
        else $error("error without abnormal stop");
    // two sync edges plus the stop edge fit inside five cycles
    both_limit_a: assert property ((i_pos_limit && i_neg_limit) [*5] |-> !o_run)
        else $error("moving on both limits");
    abs_start_a: assert property (i_abs_encoder [*4] |-> !$rose(o_run))
        else $error("start with absolute encoder");
    param_zero_a: assert property (o_status_word[14] |=> !$rose(o_run))
        else $error("start with zero parameter");
endmodule // servo_homing_chk
bind servo_homing_sequencer servo_homing_chk chk_u (.i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn), .i_rd(i_rd), .i_pos_limit(i_pos_limit), .i_neg_limit(i_neg_limit),
    .i_abs_encoder(i_abs_encoder), .o_rdata(o_rdata), .o_run(o_run),
    .o_status_word(o_status_word));

/* dv/homing_master_model.sv */
// fieldbus master model: writes control and parameters, polls status.
// assumes a slave that answers a read in the cycle after the strobe.
module homing_master_model (
    input  wire logic        i_ref_clk,
    input  wire logic [31:0] i_rdata,
    output logic [7:0]       o_addr = 8'h00,
    output logic [31:0]      o_wdata = 32'h0,
    output logic             o_wr = 1'b0,
    output logic             o_rd = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // start and stop are bit 4 edges of the written control word
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_ref_clk);
        o_wr <= 1'b0;
        o_wdata <= ~d; // released data must not echo the last value
    endtask
    // completion is judged from status bits, never from elapsed time
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        @(posedge i_ref_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_ref_clk);
        o_rd <= 1'b0;
        #1 q = i_rdata;
    endtask
endmodule // homing_master_model

/* dv/servo_homing_sequencer_tb.sv */
// bench of the homing sequencer: table of start cases, then walks.
// assumes the master model on the register port and a bound checker.
module servo_homing_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, rst_n = 1'b0, wr, rd, run, dir_pos;
    logic        pos = 1'b0, neg = 1'b0, home = 1'b0, idx = 1'b0, abs_enc = 1'b0;
    logic [15:0] torque = 16'h0000, sw;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, vel, accel, q;
    int          n_errors = 0, check_count = 0, cyc = 0;
    // method, pins pos/neg/home, error, run, positive direction
    logic [15:0] rows [25] = '{16'h0184, 16'h0244, 16'h0384, 16'h0444, 16'h2124, 16'h2284,
        16'hFAC4, 16'h0303, 16'h0322, 16'h0403, 16'h0422, 16'h0502, 16'h0523, 16'h0602,
        16'h0623, 16'h0102, 16'h0143, 16'h0203, 16'h0282, 16'hFA02, 16'hFB03, 16'hFC02,
        16'hFD03, 16'hFE02, 16'hFF03};
    always #50 clk = ~clk;
    homing_master_model m_u (.i_ref_clk(clk), .i_rdata(rdata), .o_addr(addr),
        .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
    servo_homing_sequencer #(.TICK_CYCLES(16'h0004)) dut_u (.i_ref_clk(clk),
        .i_resetn(rst_n), .i_ce(1'b1), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_pos_limit(pos), .i_neg_limit(neg),
        .i_home_switch(home), .i_index_pulse(idx), .i_abs_encoder(abs_enc),
        .i_torque(torque), .o_run(run), .o_dir_pos(dir_pos), .o_velocity(vel),
        .o_accel(accel), .o_status_word(sw));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // stop, set pins and method, restart, let it settle
    task automatic start(input logic [7:0] m, input logic [2:0] p);
        m_u.wr(8'h00, 32'h0);
        {pos, neg, home} <= p;
        m_u.wr(8'h04, {24'h0, m});
        m_u.wr(8'h00, 32'h10);
        tick(8);
        m_u.rd(8'h1C, q);
    endtask
    // hang guard, well above a clean run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            end_sim();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        m_u.rd(8'h1C, q);
        chk(q, 32'h4000);
        m_u.wr(8'h00, 32'h10);
        tick(6);
        chk(32'(run), 32'h0);
        m_u.wr(8'h08, 32'h100);
        m_u.wr(8'h0C, 32'h10);
        m_u.wr(8'h10, 32'h5);
        m_u.wr(8'h14, 32'h64);
        m_u.wr(8'h18, 32'h1);
        foreach (rows[k]) begin
            start(rows[k][15:8], rows[k][7:5]);
            chk(32'(q[13]), 32'(rows[k][2]));
            chk(32'({run, dir_pos & run}), 32'(rows[k][1:0]));
        end
        // method 1 walk; an index seen while still on the limit must not end it
        start(8'h01, 3'b000);
        chk({vel[15:0], accel[15:0]}, 32'h01000005);
        neg <= 1'b1;
        tick(6);
        chk({vel[30:0], dir_pos}, 32'h21);
        idx <= 1'b1;
        tick(3);
        idx <= 1'b0;
        neg <= 1'b0;
        tick(4);
        chk(32'(run), 32'h1);
        idx <= 1'b1;
        tick(6);
        idx <= 1'b0;
        m_u.rd(8'h1C, q);
        chk({q[15:0] & 16'h3400, 15'h0, run}, {16'h1400, 16'h0});
        start(8'hFC, 3'b000);
        torque <= 16'h0064;
        tick(4);
        chk(32'({run, dir_pos}), 32'h3);
        torque <= 16'h0000;
        tick(4);
        chk(32'(run), 32'h0);
        start(8'hFA, 3'b000);
        torque <= 16'h0064;
        tick(12);
        m_u.rd(8'h1C, q);
        chk({q[15:0] & 16'h1400, 15'h0, run}, {16'h1400, 16'h0});
        torque <= 16'h0000;
        abs_enc <= 1'b1;
        start(8'h01, 3'b000);
        chk(32'({q[13], run}), 32'h2);
        abs_enc <= 1'b0;
        start(8'hFB, 3'b000);
        m_u.wr(8'h00, 32'h0);
        tick(4);
        chk(32'(run), 32'h0);
        end_sim();
    end
endmodule // servo_homing_sequencer_tb
